// file: hw/sfp_port.sv
// Behaviour
// [RL1] Sample on rising SCK, drive on falling.
// [RL2] Works in clock modes 0 and 3.
// [RL3] Low select activates; high select idles all.
// [RL4] Pause: output released, SI and SCK ignored.
// [RL5] Host keeps select low while pausing.
// [RL6] Protect pin gates block protect writes.
// [RL7] Host holds protect pin steady during writes.
// [RL8] SI carries opcode, address, then data.
// [RL9] Array of 4096 eight-bit locations.
// [RL10] Write enable opcode sets enable latch.
// [RL11] Disable, status write, write, power-on clear latch.
// [RL12] Two select bits choose protected array part.
// [RL13] Lock plus low pin refuses status writes.
// [RL14] Status contents reset at power-on.
// [RL15] Host programs status after every power-on.
// [RL16] Fixed eight-bit instruction encodings.
// [RL17] Unknown opcode deselects for rest of frame.
// [RL18] Status write leaves bits 6-4, 1, 0.
// [RL19] Progress and reserved bits read zero; idle output released.
module sfp_port (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic chipSelectN,
  input  wire logic serialClk,
  input  wire logic serialIn,
  input  wire logic pauseN,
  input  wire logic writeProtectPinN,
  output logic      serialOut,
  output logic      serialOutEnN
);

  localparam int AW = sfp_pkg::ADDR_W;
  localparam int DW = sfp_pkg::DATA_W;

  sfp_pkg::sfp_pins_s  pinMeta;
  sfp_pkg::sfp_pins_s  pinSync;
  logic                sckLast;
  sfp_pkg::sfp_state_e state;
  sfp_pkg::sfp_state_e next_state;
  logic [2:0]          bitCnt;
  logic [DW-1:0]       rxShift;
  logic [DW-1:0]       txShift;
  logic [AW-1:0]       memAddr;
  logic                addrSecond;
  logic                readOp;
  logic                wrAllowed;
  logic                writeEnableLatch;
  logic                statusLock;
  logic                protectSel1;
  logic                protectSel0;
  logic [DW-1:0]       memArray [sfp_pkg::MEM_DEPTH];
  logic                bufReady;
  logic                wrValid;
  sfp_pkg::sfp_wr_s    wrReq;

  // Address falls in the block chosen by the two select bits.
  function automatic logic isProtected(input logic [AW-1:0] a,
                                       input logic [1:0] sel);
    case (sel)
      2'h0:    isProtected = 1'b0;
      2'h1:    isProtected = (a >= sfp_pkg::PROT_QUARTER);
      2'h2:    isProtected = (a >= sfp_pkg::PROT_HALF);
      default: isProtected = 1'b1;
    endcase
  endfunction : isProtected

  // Every pin crosses two flops; the SCK edge finder reads stage two only.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinMeta <= sfp_pkg::PINS_IDLE;
      pinSync <= sfp_pkg::PINS_IDLE;
      sckLast <= sfp_pkg::PINS_IDLE.sck; // Matches stage two: no false edge.
    end else begin
      pinMeta <= {chipSelectN, serialClk, serialIn, pauseN,
                  writeProtectPinN};
      pinSync <= pinMeta;
      sckLast <= pinSync.sck;
    end
  end

  // Edges count only while selected and not paused. Both clock modes
  // sample on the rising edge, so idle level needs no setting.
  wire active   = !pinSync.csN && pinSync.pauseN;          // [RL3] [RL4]
  wire riseEdge = active && pinSync.sck && !sckLast;       // [RL1] [RL2]
  wire fallEdge = active && !pinSync.sck && sckLast;       // [RL1] [RL2]
  wire byteDone = riseEdge && (bitCnt == sfp_pkg::BIT_LAST);
  wire [DW-1:0] rxByte = {rxShift[DW-2:0], pinSync.si};    // [RL8]
  wire [AW-1:0] addrShift = {memAddr[AW-DW-1:0], rxByte};
  wire hwLocked = statusLock && !pinSync.wpN;              // [RL13]
  wire opByte   = byteDone && (state == sfp_pkg::ST_IDLE);
  wire addrDone = byteDone && (state == sfp_pkg::ST_ADDR) && addrSecond;
  wire rdByte   = byteDone && (state == sfp_pkg::ST_RDATA);
  wire wrByte   = byteDone && (state == sfp_pkg::ST_WDATA);
  wire loadRead = (addrDone && readOp) || rdByte;
  wire sending  = (state == sfp_pkg::ST_RDATA) ||
                  (state == sfp_pkg::ST_SREAD);
  wire statusWe = byteDone && (state == sfp_pkg::ST_SWRITE);
  wire [AW-1:0] readAddr = addrDone ? addrShift : memAddr;
  wire [DW-1:0] statusWord = {statusLock, sfp_pkg::ST_RSV_VALUE,
                              protectSel1, protectSel0, writeEnableLatch,
                              sfp_pkg::ST_WIP_VALUE};    // [RL19]

  // Framing decisions taken at the end of each byte.
  always_comb begin
    next_state = state;
    if (pinSync.csN) begin
      next_state = sfp_pkg::ST_IDLE;                       // [RL3]
    end else if (byteDone) begin
      case (state)
        sfp_pkg::ST_IDLE: begin
          case (rxByte)                                    // [RL16]
            sfp_pkg::CMD_STATUS_READ:  next_state = sfp_pkg::ST_SREAD;
            sfp_pkg::CMD_STATUS_WRITE: next_state = sfp_pkg::ST_SWRITE;
            sfp_pkg::CMD_READ:         next_state = sfp_pkg::ST_ADDR;
            sfp_pkg::CMD_WRITE:        next_state = sfp_pkg::ST_ADDR;
            default:                   next_state = sfp_pkg::ST_DESEL;
          endcase                                          // [RL17]
        end
        sfp_pkg::ST_ADDR: begin
          if (addrSecond) begin
            next_state = readOp ? sfp_pkg::ST_RDATA : sfp_pkg::ST_WDATA;
          end
        end
        sfp_pkg::ST_SWRITE: next_state = sfp_pkg::ST_DESEL;
        default:            next_state = state;
      endcase
    end
  end

  // State and bit counter; a pause freezes both without ending the frame.
  always_ff @(posedge clk) begin
    if (!rst_n || pinSync.csN) begin
      state  <= sfp_pkg::ST_IDLE;
      bitCnt <= 3'h0;
    end else begin
      state  <= next_state;
      bitCnt <= riseEdge ? bitCnt + 3'h1 : bitCnt;         // [RL4]
    end
  end

  // Input shifter; bits arrive most significant first.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxShift <= '0;
    end else if (riseEdge) begin
      rxShift <= rxByte;                                   // [RL1]
    end
  end

  // Address capture and auto-increment, wrapping at the array's top.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      memAddr    <= '0;
      addrSecond <= 1'b0;
      readOp     <= 1'b0;
    end else if (opByte) begin
      readOp     <= (rxByte == sfp_pkg::CMD_READ);
      addrSecond <= 1'b0;
    end else if (byteDone && (state == sfp_pkg::ST_ADDR)) begin
      memAddr    <= addrDone && readOp ? addrShift + 1'b1 : addrShift;
      addrSecond <= 1'b1;                                  // [RL8]
    end else if (rdByte || wrByte) begin
      memAddr    <= memAddr + 1'b1;
    end
  end

  // Status register. The latch is cleared by a status write even when
  // the write is refused, and by the address phase of a memory write.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      writeEnableLatch <= sfp_pkg::ST_FIELD_RESET;         // [RL11] [RL14]
      statusLock       <= sfp_pkg::ST_FIELD_RESET;
      protectSel1      <= sfp_pkg::ST_FIELD_RESET;
      protectSel0      <= sfp_pkg::ST_FIELD_RESET;
      wrAllowed        <= 1'b0;
    end else begin
      if (opByte && rxByte == sfp_pkg::CMD_WRITE_ENABLE) begin
        writeEnableLatch <= 1'b1;                          // [RL10]
      end else if (opByte && rxByte == sfp_pkg::CMD_WRITE_DISABLE) begin
        writeEnableLatch <= 1'b0;                          // [RL11]
      end else if (statusWe || (addrDone && !readOp)) begin
        writeEnableLatch <= 1'b0;                          // [RL11]
      end
      if (statusWe && writeEnableLatch && !hwLocked) begin // [RL6] [RL13]
        statusLock  <= rxByte[sfp_pkg::ST_LOCK];           // [RL18]
        protectSel1 <= rxByte[sfp_pkg::ST_PSEL1];          // [RL12]
        protectSel0 <= rxByte[sfp_pkg::ST_PSEL0];
      end
      if (addrDone && !readOp) begin
        wrAllowed <= writeEnableLatch;
      end
    end
  end

  // Write bytes go through the buffer; outside the protected block only.
  assign wrValid    = wrByte && wrAllowed &&
                      !isProtected(memAddr, {protectSel1, protectSel0});
  assign wrReq.addr = memAddr;
  assign wrReq.data = rxByte;
  sfp_pkg::sfp_wr_s bufOut;
  logic             bufValid;
  // The array port gives way to a read fetch for one cycle.
  wire arrayReady = !loadRead;

  sfp_buf2 #(
    .W($bits(sfp_pkg::sfp_wr_s))
  ) u_wrbuf (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (wrValid),
    .inReady  (bufReady),
    .inData   (wrReq),
    .outValid (bufValid),
    .outReady (arrayReady),
    .outData  (bufOut)
  );
  a_buf_no_loss: assert property (@(posedge clk) disable iff (!rst_n)
    wrValid |-> bufReady)  // [RL9]
    else $error("Write byte offered to a full buffer.");

  // The array keeps its contents through reset, as a nonvolatile store.
  always_ff @(posedge clk) begin
    if (bufValid && arrayReady) begin
      memArray[bufOut.addr] <= bufOut.data;                // [RL9]
    end
  end

  // Output shifter: loaded on a rising edge, shifted on a falling one.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txShift <= '0;
    end else if (loadRead) begin
      txShift <= memArray[readAddr];
    end else if ((opByte && rxByte == sfp_pkg::CMD_STATUS_READ) ||
                 (byteDone && state == sfp_pkg::ST_SREAD)) begin
      txShift <= statusWord;
    end else if (fallEdge) begin
      txShift <= {txShift[DW-2:0], 1'b0};
    end
  end

  // Output pin; released when deselected, paused or not sending.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serialOut    <= 1'b0;
      serialOutEnN <= 1'b1;
    end else begin
      serialOut    <= (fallEdge && sending) ? txShift[DW-1] : serialOut;
      serialOutEnN <= !(active && sending);                // [RL4] [RL19]
    end
  end

  a_so_idle_released: assert property (@(posedge clk) disable iff (!rst_n)
    pinSync.csN |=> serialOutEnN)  // [RL19]
    else $error("Output driven while deselected.");

  a_pause_released: assert property (@(posedge clk) disable iff (!rst_n)
    !pinSync.pauseN |=> serialOutEnN && $stable(bitCnt))  // [RL4]
    else $error("Pause did not release output or freeze count.");

  a_so_on_fall: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(serialOut) |-> $past(fallEdge))  // [RL1]
    else $error("Output changed without a falling edge.");

  a_rise_sample: assert property (@(posedge clk) disable iff (!rst_n)
    riseEdge |=> rxShift[0] == $past(pinSync.si))  // [RL1]
    else $error("Input bit not taken on rising edge.");

  a_wel_set: assert property (@(posedge clk) disable iff (!rst_n)
    opByte && rxByte == sfp_pkg::CMD_WRITE_ENABLE |=> writeEnableLatch)  // [RL10]
    else $error("Enable latch not set.");

  a_wel_cleared: assert property (@(posedge clk) disable iff (!rst_n)
    (opByte && rxByte == sfp_pkg::CMD_WRITE_DISABLE) || statusWe
    |=> !writeEnableLatch)  // [RL11]
    else $error("Enable latch not cleared.");

  a_lock_refuses: assert property (@(posedge clk) disable iff (!rst_n)
    statusWe && hwLocked |=> $stable(statusWord[7:2]))  // [RL13]
    else $error("Status written under hardware protection.");

  a_fixed_bits: assert property (@(posedge clk) disable iff (!rst_n)
    statusWord[6:4] == sfp_pkg::ST_RSV_VALUE && !statusWord[0])  // [RL18]
    else $error("Reserved or progress bit not zero.");

  a_bad_opcode: assert property (@(posedge clk) disable iff (!rst_n)
    opByte && rxByte != sfp_pkg::CMD_STATUS_READ &&
    rxByte != sfp_pkg::CMD_STATUS_WRITE && rxByte != sfp_pkg::CMD_READ &&
    rxByte != sfp_pkg::CMD_WRITE ##1 !pinSync.csN
    |-> state == sfp_pkg::ST_DESEL)  // [RL17]
    else $error("Unknown opcode did not deselect.");

  a_protect_block: assert property (@(posedge clk) disable iff (!rst_n)
    bufValid && arrayReady |->
      !isProtected(bufOut.addr, {protectSel1, protectSel0}))  // [RL12]
    else $error("Write landed in protected block.");

endmodule : sfp_port

// file: hw/sfp_pkg.sv
package sfp_pkg;

  // Array geometry and serial framing.
  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 8;
  localparam int MEM_DEPTH = 4096;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Instruction encodings.
  localparam logic [7:0] CMD_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_STATUS_READ   = 8'h05;
  localparam logic [7:0] CMD_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] CMD_READ          = 8'h03;
  localparam logic [7:0] CMD_WRITE         = 8'h02;

  // Status register bit positions and fixed fields.
  localparam int ST_LOCK  = 7;
  localparam int ST_PSEL1 = 3;
  localparam int ST_PSEL0 = 2;
  localparam logic [2:0] ST_RSV_VALUE = 3'h0;
  localparam logic       ST_WIP_VALUE = 1'h0;
  localparam logic       ST_FIELD_RESET = 1'h0;

  // Lowest protected address for the quarter and half settings.
  localparam logic [ADDR_W-1:0] PROT_QUARTER = 12'hC00;
  localparam logic [ADDR_W-1:0] PROT_HALF    = 12'h800;

  // Front-end states, one-hot.
  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_ADDR   = 7'h02,
    ST_WDATA  = 7'h04,
    ST_RDATA  = 7'h08,
    ST_SREAD  = 7'h10,
    ST_SWRITE = 7'h20,
    ST_DESEL  = 7'h40
  } sfp_state_e;

  // Serial pins as sampled from outside the clock domain.
  typedef struct packed {
    logic csN;
    logic sck;
    logic si;
    logic pauseN;
    logic wpN;
  } sfp_pins_s;

  localparam sfp_pins_s PINS_IDLE = 5'h1B;

  // One array write request.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } sfp_wr_s;

endpackage : sfp_pkg

// file: hw/sfp_buf2.sv
module sfp_buf2 #(
  parameter int W = 20
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);

  logic [W-1:0] slot [2];
  logic         wrPtr;
  logic         rdPtr;
  logic [1:0]   count;
  logic [1:0]   next_count;
  wire          push = inValid && inReady;
  wire          pop  = outValid && outReady;

  // Two slots: full at two, so a stalled drain pushes back on the source.
  assign inReady    = (count != 2'h2);
  assign outValid   = (count != 2'h0);
  assign outData    = slot[rdPtr];
  assign next_count = count + {1'b0, push} - {1'b0, pop};

  // Pointers and occupancy.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'h0;
    end else begin
      wrPtr <= wrPtr ^ push;
      rdPtr <= rdPtr ^ pop;
      count <= next_count;
    end
  end

  // Storage needs no reset; only counted slots are ever read.
  always_ff @(posedge clk) begin
    if (push) begin
      slot[wrPtr] <= inData;
    end
  end

endmodule : sfp_buf2

// file: verif/sfp_host_model.sv
module sfp_host_model (
  output logic      csN,
  output logic      sck,
  output logic      si,
  output logic      pauseN,
  output logic      wpN,
  input  wire logic soWire
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime HALF = 62.5ns;
  sfp_pkg::sfp_pins_s pins;
  logic               mode3;

  // The pin bundle fans out to one net per pin.
  assign {csN, sck, si, pauseN, wpN} = pins;

  // Pins start idle; the link clock stands still outside frames.
  initial begin
    pins  = sfp_pkg::PINS_IDLE;
    mode3 = 1'b0;
  end

  // The 0.3 ns offset keeps every link edge clear of the system clock.
  task automatic start(input logic m3);
    #0.3;
    mode3    = m3;
    pins.sck = m3; // Idle level picks mode 0 or mode 3.
    #HALF;
    pins.csN = 1'b0;
    #HALF;
  endtask : start

  // One byte, MSB first: shift on the fall, sample on the rise.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      pins.sck = 1'b0;
      pins.si  = tx[i];
      #HALF;
      pins.sck = 1'b1;
      rx[i]    = soWire;
      #HALF;
    end
  endtask : xfer

  // Closing a frame flips the data line so no stale bit lingers.
  task automatic stop();
    pins.sck = mode3;
    #HALF;
    pins.csN = 1'b1;
    pins.si  = ~pins.si;
    #(2 * HALF - 0.3);
  endtask : stop

  // Select is left low for the whole pause.
  task automatic set_pause(input logic v);
    pins.pauseN = v;
    #(2 * HALF);
  endtask : set_pause

  // Only called between frames, so no write sees the pin move.
  task automatic set_wp(input logic v);
    #0.3;
    pins.wpN = v;
    #(2 * HALF - 0.3);
  endtask : set_wp
endmodule : sfp_host_model

// file: verif/sfp_port_tb.sv
module sfp_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic               clk;
  logic               rst_n;
  wire                csN;
  wire                sck;
  wire                si;
  wire                pauseN;
  wire                wpN;
  logic               serialOut;
  logic               serialOutEnN;
  wire                soWire;
  int                 errors;
  int                 compares;
  logic [7:0]         rx;

  // The output pin floats whenever the enable is high.
  assign soWire = serialOutEnN ? 1'bz : serialOut;

  sfp_port dut_u (
    .clk              (clk),
    .rst_n            (rst_n),
    .chipSelectN      (csN),
    .serialClk        (sck),
    .serialIn         (si),
    .pauseN           (pauseN),
    .writeProtectPinN (wpN),
    .serialOut        (serialOut),
    .serialOutEnN     (serialOutEnN)
  );

  sfp_host_model host_u (
    .csN    (csN),
    .sck    (sck),
    .si     (si),
    .pauseN (pauseN),
    .wpN    (wpN),
    .soWire (soWire)
  );

  // System clock, 4 ns period.
  initial clk = 1'b0;
  always #2 clk = ~clk;

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  // Reset is held for six clocks and released just after an edge.
  task automatic pulse_reset();
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask : pulse_reset

  task automatic cmd(input logic m3, input logic [7:0] op);
    host_u.start(m3);
    host_u.xfer(op, rx);
    host_u.stop();
  endtask : cmd

  task automatic cmd_status_write(input logic [7:0] d);
    host_u.start(1'b0);
    host_u.xfer(sfp_pkg::CMD_STATUS_WRITE, rx);
    host_u.xfer(d, rx);
    host_u.stop();
  endtask : cmd_status_write

  // Reads two status bytes; the value repeats while select stays low.
  task automatic status(input logic m3, input logic [7:0] exp,
                        input string what);
    host_u.start(m3);
    host_u.xfer(sfp_pkg::CMD_STATUS_READ, rx);
    host_u.xfer(8'h00, rx);
    check(what, exp, rx);
    host_u.xfer(8'h00, rx);
    check(what, exp, rx);
    host_u.stop();
  endtask : status

  // Two-byte array access; on a read d0 and d1 are the expected bytes.
  task automatic mem(input logic [7:0] op, input logic [11:0] a,
                     input logic [7:0] d0, input logic [7:0] d1);
    if (op == sfp_pkg::CMD_WRITE) cmd(1'b0, sfp_pkg::CMD_WRITE_ENABLE);
    host_u.start(1'b0);
    host_u.xfer(op, rx);
    host_u.xfer({4'h0, a[11:8]}, rx);
    host_u.xfer(a[7:0], rx);
    host_u.xfer(d0, rx);
    if (op == sfp_pkg::CMD_READ) check("read byte 0", d0, rx);
    host_u.xfer(d1, rx);
    if (op == sfp_pkg::CMD_READ) check("read byte 1", d1, rx);
    host_u.stop();
  endtask : mem

  task automatic test_reset();
    check("idle output", 8'hZZ, {8{soWire}});
    status(1'b0, 8'h00, "status after reset");
    $display("test_reset done");
  endtask : test_reset

  task automatic test_latch();
    cmd(1'b1, sfp_pkg::CMD_WRITE_ENABLE);
    status(1'b1, 8'h02, "latch set, mode 3");
    status(1'b0, 8'h02, "latch set, mode 0");
    cmd(1'b0, sfp_pkg::CMD_WRITE_DISABLE);
    status(1'b1, 8'h00, "latch after disable");
    $display("test_latch done");
  endtask : test_latch

  // Status writes: refused without latch, then under the hardware lock.
  task automatic test_status_write();
    cmd_status_write(8'hFF);
    status(1'b0, 8'h00, "write without latch");
    cmd(1'b0, sfp_pkg::CMD_WRITE_ENABLE);
    cmd_status_write(8'hFF);
    status(1'b0, 8'h8C, "fixed bits kept");
    host_u.set_wp(1'b0);
    cmd(1'b0, sfp_pkg::CMD_WRITE_ENABLE);
    cmd_status_write(8'h00);
    status(1'b0, 8'h8C, "locked status");
    host_u.set_wp(1'b1);
    cmd(1'b0, sfp_pkg::CMD_WRITE_ENABLE);
    cmd_status_write(8'h00);
    status(1'b0, 8'h00, "unlocked status");
    $display("test_status_write done");
  endtask : test_status_write

  // Address wrap, latch clear after a write, and the quarter protection.
  task automatic test_mem();
    mem(sfp_pkg::CMD_WRITE, 12'hFFF, 8'hA5, 8'h3C);
    status(1'b0, 8'h00, "latch after write");
    mem(sfp_pkg::CMD_READ, 12'hFFF, 8'hA5, 8'h3C);
    mem(sfp_pkg::CMD_WRITE, 12'hBFF, 8'h11, 8'h22);
    mem(sfp_pkg::CMD_WRITE, 12'h7FF, 8'h33, 8'h99);
    cmd(1'b0, sfp_pkg::CMD_WRITE_ENABLE);
    cmd_status_write(8'h04);
    mem(sfp_pkg::CMD_WRITE, 12'hBFF, 8'h66, 8'h77);
    mem(sfp_pkg::CMD_READ, 12'hBFF, 8'h66, 8'h22);
    cmd(1'b0, sfp_pkg::CMD_WRITE_ENABLE);
    cmd_status_write(8'h08);
    mem(sfp_pkg::CMD_WRITE, 12'h7FF, 8'h44, 8'h55);
    mem(sfp_pkg::CMD_READ, 12'h7FF, 8'h44, 8'h99);
    cmd(1'b0, sfp_pkg::CMD_WRITE_ENABLE);
    cmd_status_write(8'h00);
    $display("test_mem done");
  endtask : test_mem

  // A pause mid-read floats the output and must not advance the address.
  task automatic test_pause();
    host_u.start(1'b0);
    host_u.xfer(sfp_pkg::CMD_READ, rx);
    host_u.xfer(8'h0F, rx);
    host_u.xfer(8'hFF, rx);
    host_u.xfer(8'h00, rx);
    check("byte before pause", 8'hA5, rx);
    host_u.set_pause(1'b0);
    check("paused output", 8'hZZ, {8{soWire}});
    host_u.xfer(8'hFF, rx);
    check("output in pause", 8'hZZ, rx);
    host_u.set_pause(1'b1);
    host_u.xfer(8'h00, rx);
    check("byte after pause", 8'h3C, rx);
    host_u.stop();
    $display("test_pause done");
  endtask : test_pause

  // An unknown opcode drops the rest of the frame, enable included.
  task automatic test_bad_opcode();
    host_u.start(1'b0);
    host_u.xfer(8'hAB, rx);
    host_u.xfer(sfp_pkg::CMD_WRITE_ENABLE, rx);
    host_u.xfer(sfp_pkg::CMD_STATUS_READ, rx);
    host_u.xfer(8'h00, rx);
    check("output after bad opcode", 8'hZZ, rx);
    host_u.stop();
    status(1'b0, 8'h00, "latch after bad opcode");
    $display("test_bad_opcode done");
  endtask : test_bad_opcode

  // A mid-run reset clears the status but keeps the array's contents.
  task automatic test_power_cycle();
    cmd(1'b0, sfp_pkg::CMD_WRITE_ENABLE);
    cmd_status_write(8'h0C);
    mem(sfp_pkg::CMD_WRITE, 12'hFFF, 8'h00, 8'h00);
    cmd(1'b0, sfp_pkg::CMD_WRITE_ENABLE);
    status(1'b0, 8'h0E, "status before reset");
    @(posedge clk);
    #1;
    pulse_reset();
    status(1'b0, 8'h00, "status after power cycle");
    mem(sfp_pkg::CMD_READ, 12'hFFF, 8'hA5, 8'h3C);
    $display("test_power_cycle done");
  endtask : test_power_cycle

  // A stuck frame cannot hold the run forever.
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    conclude();
  end

  // Reset, then each scenario in turn.
  initial begin
    errors   = 0;
    compares = 0;
    pulse_reset();
    test_reset();
    test_latch();
    test_status_write();
    test_mem();
    test_pause();
    test_bad_opcode();
    test_power_cycle();
    conclude();
  end
endmodule : sfp_port_tb
